// ===== src/ssp_defs.svh
// What this block does
// - parameter table lists 4KB/20h, 32KB/52h, 64KB/D8h erase; fourth type reads zero
// - table byte 9Bh gives EBh quad fast read; byte before: 8 dummy bits
// - one 1024-byte security area, addressed apart from the main array
// - security erase 44h accepted only while write enable latch is 1
// - erase runs only if chip select rises right after last address bit
// - erase is self-timed; write-in-progress is 1 during it, 0 after
// - finished security erase clears the write enable latch
// - security lock bit set means security erase and program are ignored
// - program 42h needs latch set; 1 to 256 bytes, only clears bits
// - security read 48h: 24-bit address, eight dummy clocks, then data
// - bits latched on rising clock; read data out on falling, msb first
// - security read address increments, rolls 3FFh to 00h until deselect
// - security read during a busy cycle is ignored; the cycle continues
// - read-parameter command C0h taken only in quad command mode
// - dummy field bits 5-4 give 2, 4, 6 or 8 quad read dummy clocks
// - wrap field bits 1-0 give 8, 16, 32 or 64 byte wrap length
// - after power-up or reset command: wrap 8 bytes, 2 dummy clocks
// - serial mode wrap comes from 77h wrap bits; kept entering quad mode
// - quad 0Ch reads like fast read, wrapping inside aligned wrap window
// - enter-quad command 38h ignored while quad enable bit is 0
// - accepted reset restores read params, wrap, latch to power-on values
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

`define SSP_OP_WREN       8'h06
`define SSP_OP_WRDI       8'h04
`define SSP_OP_SEC_ERASE  8'h44
`define SSP_OP_SEC_PROG   8'h42
`define SSP_OP_SEC_READ   8'h48
`define SSP_OP_TBL_READ   8'h5A
`define SSP_OP_SET_PARAM  8'hC0
`define SSP_OP_WRAP_READ  8'h0C
`define SSP_OP_SET_WRAP   8'h77
`define SSP_OP_QUAD_ON    8'h38
`define SSP_OP_QUAD_OFF   8'hFF
`define SSP_OP_RST_EN     8'h66
`define SSP_OP_RST        8'h99

`define SSP_BITS_OP       16'h0008
`define SSP_BITS_PARAM    16'h0010
`define SSP_BITS_ADDR     16'h0020
`define SSP_BITS_DATA0    16'h0028
`define SSP_BITS_SAT      16'hFFF0

`define SSP_DUMMY_MSB     5
`define SSP_DUMMY_LSB     4
`define SSP_WRAP_MSB      1
`define SSP_WRAP_LSB      0
`define SSP_WSIZE_MSB     5
`define SSP_WSIZE_LSB     4
`define SSP_DUMMY_RST     2'h0
`define SSP_WRAP_RST      2'h0

`define SSP_SEC_BYTES     16'h0400
`define SSP_PAGE_LAST     16'h00FF
`define SSP_ERASED        8'hFF

`define SSP_TBL_A_22_MODE 8'h96
`define SSP_TBL_A_22_NONE 8'h97
`define SSP_TBL_A_QPI_SET 8'h9A
`define SSP_TBL_A_QPI_OP  8'h9B
`define SSP_TBL_A_T1_SIZE 8'h9C
`define SSP_TBL_A_T1_OP   8'h9D
`define SSP_TBL_A_T2_SIZE 8'h9E
`define SSP_TBL_A_T2_OP   8'h9F
`define SSP_TBL_A_T3_SIZE 8'hA0
`define SSP_TBL_A_T3_OP   8'hA1
`define SSP_TBL_A_T4_SIZE 8'hA2
`define SSP_TBL_A_T4_OP   8'hA3
`define SSP_TBL_D_QPI_SET 8'h08
`define SSP_TBL_D_QPI_OP  8'hEB
`define SSP_TBL_D_T1_SIZE 8'h0C
`define SSP_TBL_D_T1_OP   8'h20
`define SSP_TBL_D_T2_SIZE 8'h0F
`define SSP_TBL_D_T2_OP   8'h52
`define SSP_TBL_D_T3_SIZE 8'h10
`define SSP_TBL_D_T3_OP   8'hD8
`define SSP_TBL_D_ZERO    8'h00
`define SSP_TBL_D_RSVD    8'hFF

`define SSP_CLK_PERIOD_NS     25
`define SSP_SEC_ERASE_TIME_NS 100000
`define SSP_SEC_ERASE_CYC \
    ((`SSP_SEC_ERASE_TIME_NS + `SSP_CLK_PERIOD_NS - 1) / `SSP_CLK_PERIOD_NS)

`endif

// ===== src/ssp_pkg.sv
package ssp_pkg;

    typedef enum logic [2:0] {
        SSP_IDLE  = 3'b001,
        SSP_ERASE = 3'b010,
        SSP_PROG  = 3'b100
    } ssp_state_t;

    // what the link side captured in the last frame
    typedef struct packed {
        logic [7:0]  op;
        logic [23:0] addr;
        logic [7:0]  param;
        logic [15:0] bits;
    } ssp_frame_t;

    typedef struct packed {
        logic [1:0] dummy;
        logic [1:0] wrap;
    } ssp_rdpar_t;

endpackage

// ===== src/ssp_core.sv
`timescale 1ns/1ps
`include "ssp_defs.svh"

module ssp_core #(
    parameter int ERASE_CYCLES = `SSP_SEC_ERASE_CYC
) (
    input wire logic clk_i,                  // system clock, 40 MHz
    input wire logic nrst_i,                 // async reset, active low
    input wire logic sclk_i,                 // serial clock from host
    input wire logic cs_n_i,                 // chip select, active low
    input wire logic [3:0] io_i,             // data lines in
    output logic [3:0] io_o,                 // data lines out
    output logic [3:0] io_oe_o,              // data line drive enables
    input wire logic qe_i,                   // quad enable bit
    input wire logic lock_i,                 // security lock bit
    output logic wip_o,                      // write in progress
    output logic wel_o,                      // write enable latch
    output logic quad_mode_o,                // quad command mode
    output ssp_pkg::ssp_rdpar_t rdpar_o,     // read parameter fields
    output logic [23:0] main_rd_addr_o,      // main array read address
    input wire logic [7:0] main_rd_data_i    // main array read data
);

    function automatic logic [7:0] tbl_byte(input logic [7:0] a);
        logic [7:0] d;
        d = `SSP_TBL_D_RSVD;
        case (a)
            `SSP_TBL_A_22_MODE: d = `SSP_TBL_D_ZERO;
            `SSP_TBL_A_22_NONE: d = `SSP_TBL_D_ZERO;
            `SSP_TBL_A_QPI_SET: d = `SSP_TBL_D_QPI_SET;
            `SSP_TBL_A_QPI_OP: d = `SSP_TBL_D_QPI_OP;
            `SSP_TBL_A_T1_SIZE: d = `SSP_TBL_D_T1_SIZE;
            `SSP_TBL_A_T1_OP: d = `SSP_TBL_D_T1_OP;
            `SSP_TBL_A_T2_SIZE: d = `SSP_TBL_D_T2_SIZE;
            `SSP_TBL_A_T2_OP: d = `SSP_TBL_D_T2_OP;
            `SSP_TBL_A_T3_SIZE: d = `SSP_TBL_D_T3_SIZE;
            `SSP_TBL_A_T3_OP: d = `SSP_TBL_D_T3_OP;
            `SSP_TBL_A_T4_SIZE: d = `SSP_TBL_D_ZERO;
            `SSP_TBL_A_T4_OP: d = `SSP_TBL_D_ZERO;
            default: d = `SSP_TBL_D_RSVD;
        endcase
        return d;
    endfunction

    function automatic logic [23:0] next_addr(input logic [7:0] op,
                                              input logic [23:0] a,
                                              input logic [1:0] wrap);
        logic [23:0] m;
        logic [23:0] n;
        m = {18'h00000, (6'h07 << wrap) | 6'h07};
        n = a + 24'h000001;
        case (op)
            `SSP_OP_SEC_READ: n = {a[23:10], a[9:0] + 10'h001};
            `SSP_OP_WRAP_READ: n = (a & ~m) | (n & m);
            default: n = a + 24'h000001;
        endcase
        return n;
    endfunction

    // settings owned by the clk_i side; they only change after a frame
    // ends and the host must wait for that, so the link reads them live
    ssp_pkg::ssp_state_t state_reg;
    logic wel_reg;
    logic quad_reg;
    logic rst_en_reg;
    ssp_pkg::ssp_rdpar_t rdpar_reg;
    logic busy;

    // ---------------- link side, sclk_i ----------------
    logic link_rst_n;
    logic first_reg;
    logic [15:0] bcnt_reg;
    logic [15:0] bcnt_next;
    logic [15:0] step;
    logic [7:0] sh_reg;
    logic [7:0] sh_next;
    logic [7:0] op_reg;
    logic [23:0] addr_reg;
    logic [7:0] param_reg;
    logic [23:0] rd_addr_reg;
    logic fetch_tgl_reg;
    logic [7:0] pgm_data_reg;
    logic [7:0] pgm_idx_reg;
    logic pgm_tgl_reg;
    logic [15:0] data_start;
    logic rd_ok;
    logic fetch_op;
    logic at_byte;
    logic byte_done;
    logic [7:0] out_sh_reg;
    logic [7:0] out_sh_next;
    logic [7:0] fetch_data_reg;

    assign link_rst_n = nrst_i & ~cs_n_i;
    assign busy = (state_reg != ssp_pkg::SSP_IDLE);
    assign step = quad_reg ? 16'h0004 : 16'h0001;
    assign bcnt_next = first_reg ? step :
                       (bcnt_reg > `SSP_BITS_SAT) ? bcnt_reg : bcnt_reg + step;
    assign sh_next = quad_reg ? {sh_reg[3:0], io_i} : {sh_reg[6:0], io_i[0]};
    assign byte_done = (bcnt_next[2:0] == 3'h0);

    always_comb begin
        data_start = `SSP_BITS_DATA0;
        if (op_reg == `SSP_OP_WRAP_READ) begin
            data_start = `SSP_BITS_ADDR +
                {10'h000, {1'b0, rdpar_reg.dummy} + 3'h1, 3'h0};
        end
    end

    // a security read seen while busy never drives the pins
    assign rd_ok = (op_reg == `SSP_OP_SEC_READ && !quad_reg && !busy) ||
                   (op_reg == `SSP_OP_TBL_READ && !quad_reg) ||
                   (op_reg == `SSP_OP_WRAP_READ && quad_reg);
    assign fetch_op = rd_ok && op_reg != `SSP_OP_TBL_READ;
    assign at_byte = rd_ok && !first_reg && bcnt_reg >= data_start &&
                     ((bcnt_reg - data_start) & 16'h0007) == 16'h0000;

    // marks the first edge of a frame; sclk may stand still between frames
    always_ff @(posedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    always_ff @(posedge sclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bcnt_reg <= 16'h0000;
            sh_reg <= 8'h00;
            op_reg <= 8'h00;
            addr_reg <= 24'h000000;
            param_reg <= 8'h00;
        end else begin
            bcnt_reg <= bcnt_next;
            sh_reg <= sh_next;
            if (bcnt_next == `SSP_BITS_OP) begin
                op_reg <= sh_next;
            end
            if (byte_done && bcnt_next > `SSP_BITS_OP &&
                bcnt_next <= `SSP_BITS_ADDR) begin
                addr_reg <= {addr_reg[15:0], sh_next};
            end
            if (byte_done && bcnt_next > `SSP_BITS_OP) begin
                param_reg <= sh_next;
            end
        end
    end

    // read address walks and asks clk_i side for the next byte
    always_ff @(posedge sclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_addr_reg <= 24'h000000;
            fetch_tgl_reg <= 1'b0;
        end else begin
            if (!first_reg && bcnt_next == `SSP_BITS_ADDR) begin
                rd_addr_reg <= {addr_reg[15:0], sh_next};
                if (fetch_op) begin
                    fetch_tgl_reg <= ~fetch_tgl_reg;
                end
            end else if (at_byte) begin
                rd_addr_reg <= next_addr(op_reg, rd_addr_reg,
                                         rdpar_reg.wrap);
                if (fetch_op) begin
                    fetch_tgl_reg <= ~fetch_tgl_reg;
                end
            end
        end
    end

    // program bytes are handed over one at a time, wrapping in the page
    always_ff @(posedge sclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pgm_data_reg <= 8'h00;
            pgm_idx_reg <= 8'h00;
            pgm_tgl_reg <= 1'b0;
        end else if (!first_reg && op_reg == `SSP_OP_SEC_PROG && byte_done &&
                     bcnt_next >= `SSP_BITS_DATA0) begin
            pgm_data_reg <= sh_next;
            pgm_idx_reg <= addr_reg[7:0] +
                8'((bcnt_next - `SSP_BITS_DATA0) >> 3);
            pgm_tgl_reg <= ~pgm_tgl_reg;
        end
    end

    always_comb begin
        out_sh_next = quad_reg ? {out_sh_reg[3:0], 4'h0} :
                                 {out_sh_reg[6:0], 1'b0};
        if (at_byte) begin
            out_sh_next = (op_reg == `SSP_OP_TBL_READ) ?
                          tbl_byte(rd_addr_reg[7:0]) : fetch_data_reg;
        end
    end

    // output side on falling edges, released as soon as cs_n_i rises
    always_ff @(negedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            out_sh_reg <= 8'h00;
            io_o <= 4'h0;
            io_oe_o <= 4'h0;
        end else begin
            out_sh_reg <= out_sh_next;
            io_o <= quad_reg ? out_sh_next[7:4] :
                               {2'h0, out_sh_next[7], 1'b0};
            if (at_byte) begin
                io_oe_o <= quad_reg ? 4'hF : 4'h2;
            end
        end
    end

    // ---------------- core side, clk_i ----------------
    ssp_pkg::ssp_frame_t frame;
    logic [2:0] cs_s_reg;
    logic [2:0] pg_s_reg;
    logic [2:0] fe_s_reg;
    logic [1:0] qe_s_reg;
    logic [1:0] lock_s_reg;
    logic frame_end;
    logic frame_start;
    logic pgm_evt;
    logic fetch_evt;
    logic [15:0] cnt_reg;
    logic [1:0] quarter_reg;
    logic [7:0] sec_mem [0:1023];
    logic [7:0] page_buf [0:255];
    logic [255:0] page_vld_reg;
    logic fetch_pend_reg;
    logic fetch_main_reg;
    logic [9:0] fetch_addr_reg;
    logic erase_done;
    logic prog_done;

    assign frame = '{op: op_reg, addr: addr_reg, param: param_reg,
                     bits: bcnt_reg};
    assign frame_end = cs_s_reg[1] & ~cs_s_reg[2];
    assign frame_start = ~cs_s_reg[1] & cs_s_reg[2];
    assign pgm_evt = pg_s_reg[1] ^ pg_s_reg[2];
    assign fetch_evt = fe_s_reg[1] ^ fe_s_reg[2];
    assign erase_done = state_reg == ssp_pkg::SSP_ERASE &&
                        cnt_reg == 16'(ERASE_CYCLES - 1);
    assign prog_done = state_reg == ssp_pkg::SSP_PROG &&
                       cnt_reg == `SSP_PAGE_LAST;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cs_s_reg <= 3'h7;
            pg_s_reg <= 3'h0;
            fe_s_reg <= 3'h0;
            qe_s_reg <= 2'h0;
            lock_s_reg <= 2'h0;
        end else begin
            cs_s_reg <= {cs_s_reg[1:0], cs_n_i};
            pg_s_reg <= {pg_s_reg[1:0], pgm_tgl_reg};
            fe_s_reg <= {fe_s_reg[1:0], fetch_tgl_reg};
            qe_s_reg <= {qe_s_reg[0], qe_i};
            lock_s_reg <= {lock_s_reg[0], lock_i};
        end
    end

    // commands act when the frame ends; frames arriving while busy are dropped
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= ssp_pkg::SSP_IDLE;
            cnt_reg <= 16'h0000;
            quarter_reg <= 2'h0;
            wel_reg <= 1'b0;
            quad_reg <= 1'b0;
            rst_en_reg <= 1'b0;
            rdpar_reg <= '{dummy: `SSP_DUMMY_RST, wrap: `SSP_WRAP_RST};
        end else if (state_reg != ssp_pkg::SSP_IDLE) begin
            cnt_reg <= cnt_reg + 16'h0001;
            if (erase_done || prog_done) begin
                state_reg <= ssp_pkg::SSP_IDLE;
                wel_reg <= 1'b0;
            end
        end else if (frame_end) begin
            rst_en_reg <= frame.op == `SSP_OP_RST_EN &&
                          frame.bits == `SSP_BITS_OP;
            cnt_reg <= 16'h0000;
            quarter_reg <= frame.addr[9:8];
            case (frame.op)
                `SSP_OP_WREN: begin
                    if (frame.bits == `SSP_BITS_OP) begin
                        wel_reg <= 1'b1;
                    end
                end
                `SSP_OP_WRDI: begin
                    if (frame.bits == `SSP_BITS_OP) begin
                        wel_reg <= 1'b0;
                    end
                end
                `SSP_OP_SEC_ERASE: begin
                    if (frame.bits == `SSP_BITS_ADDR &&
                        wel_reg && !lock_s_reg[1]) begin
                        state_reg <= ssp_pkg::SSP_ERASE;
                    end
                end
                `SSP_OP_SEC_PROG: begin
                    if (frame.bits >= `SSP_BITS_DATA0 &&
                        frame.bits[2:0] == 3'h0 &&
                        wel_reg && !lock_s_reg[1]) begin
                        state_reg <= ssp_pkg::SSP_PROG;
                    end
                end
                `SSP_OP_SET_PARAM: begin
                    if (quad_reg && frame.bits == `SSP_BITS_PARAM) begin
                        rdpar_reg.dummy <= frame.param[`SSP_DUMMY_MSB:
                                                       `SSP_DUMMY_LSB];
                        rdpar_reg.wrap <= frame.param[`SSP_WRAP_MSB:
                                                      `SSP_WRAP_LSB];
                    end
                end
                `SSP_OP_SET_WRAP: begin
                    if (!quad_reg && frame.bits == `SSP_BITS_DATA0) begin
                        rdpar_reg.wrap <= frame.param[`SSP_WSIZE_MSB:
                                                      `SSP_WSIZE_LSB];
                    end
                end
                `SSP_OP_QUAD_ON: begin
                    // wrap setting and latch are left as they are
                    if (!quad_reg && qe_s_reg[1] &&
                        frame.bits == `SSP_BITS_OP) begin
                        quad_reg <= 1'b1;
                    end
                end
                `SSP_OP_QUAD_OFF: begin
                    if (quad_reg && frame.bits == `SSP_BITS_OP) begin
                        quad_reg <= 1'b0;
                    end
                end
                `SSP_OP_RST: begin
                    if (rst_en_reg && frame.bits == `SSP_BITS_OP) begin
                        wel_reg <= 1'b0;
                        quad_reg <= 1'b0;
                        rdpar_reg <= '{dummy: `SSP_DUMMY_RST,
                                       wrap: `SSP_WRAP_RST};
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // staged program bytes; a new byte beats a same-cycle frame clear
    always_ff @(posedge clk_i) begin
        if (pgm_evt) begin
            page_buf[pgm_idx_reg] <= pgm_data_reg;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            page_vld_reg <= '0;
        end else begin
            if (frame_start) begin
                page_vld_reg <= '0;
            end
            if (pgm_evt) begin
                page_vld_reg[pgm_idx_reg] <= 1'b1;
            end
        end
    end

    // erase sweeps the area once; program can only clear bits
    always_ff @(posedge clk_i) begin
        if (state_reg == ssp_pkg::SSP_ERASE && cnt_reg < `SSP_SEC_BYTES) begin
            sec_mem[cnt_reg[9:0]] <= `SSP_ERASED;
        end
        if (state_reg == ssp_pkg::SSP_PROG && page_vld_reg[cnt_reg[7:0]]) begin
            sec_mem[{quarter_reg, cnt_reg[7:0]}] <=
                sec_mem[{quarter_reg, cnt_reg[7:0]}] &
                page_buf[cnt_reg[7:0]];
        end
    end

    // read fetch: one cycle to present the address, one to take the byte
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fetch_pend_reg <= 1'b0;
            fetch_main_reg <= 1'b0;
            fetch_addr_reg <= 10'h000;
            fetch_data_reg <= 8'h00;
            main_rd_addr_o <= 24'h000000;
        end else begin
            fetch_pend_reg <= fetch_evt;
            if (fetch_evt) begin
                fetch_main_reg <= op_reg == `SSP_OP_WRAP_READ;
                fetch_addr_reg <= rd_addr_reg[9:0];
                main_rd_addr_o <= rd_addr_reg;
            end
            if (fetch_pend_reg) begin
                fetch_data_reg <= fetch_main_reg ? main_rd_data_i :
                                  sec_mem[fetch_addr_reg];
            end
        end
    end

    assign wip_o = busy;
    assign wel_o = wel_reg;
    assign quad_mode_o = quad_reg;
    assign rdpar_o = rdpar_reg;

endmodule

// ===== sim/ssp_monitor.sv
`timescale 1ns/1ps
module ssp_monitor #(
    parameter int ERASE_CYCLES = 4000
) (
    input wire logic clk_i, // system clock
    input wire logic nrst_i, // reset, active low
    input wire logic cs_n_i, // chip select
    input wire logic [3:0] io_oe_o, // drive enables
    input wire logic qe_i, // quad enable bit
    input wire logic lock_i, // security lock bit
    input wire logic wip_o, // write in progress
    input wire logic wel_o, // write enable latch
    input wire logic quad_mode_o, // quad command mode
    input wire ssp_pkg::ssp_rdpar_t rdpar_o // read parameters
);
    logic [15:0] busy_cnt;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) busy_cnt <= 16'h0000;
        else busy_cnt <= wip_o ? busy_cnt + 16'h0001 : 16'h0000;
    end
    oe_idle_a: assert property (cs_n_i |-> io_oe_o == 4'h0)
        else $error("lines driven while deselected");
    oe_code_a: assert property (io_oe_o inside {4'h0, 4'h2, 4'hF})
        else $error("odd drive enable pattern");
    oe_quad_a: assert property (io_oe_o == 4'hF |-> quad_mode_o)
        else $error("quad drive outside quad mode");
    busy_start_a: assert property ($rose(wip_o) |->
        cs_n_i && !lock_i && $past(wel_o)) else $error("bad busy start");
    busy_hold_a: assert property ($rose(wip_o) |=> wip_o [*8])
        else $error("busy dropped early");
    wel_clear_a: assert property ($fell(wip_o) |-> ##[0:2] !wel_o)
        else $error("latch kept after cycle");
    // slack of two cycles covers the end-of-cycle handover
    busy_len_a: assert property ($fell(wip_o) |->
        (busy_cnt >= 16'h00FE && busy_cnt <= 16'h0102) ||
        (busy_cnt + 2 >= ERASE_CYCLES && busy_cnt <= ERASE_CYCLES + 2))
        else $error("busy length wrong");
    dummy_src_a: assert property ($changed(rdpar_o.dummy) |->
        $past(quad_mode_o)) else $error("dummy set outside quad");
    quad_on_a: assert property ($rose(quad_mode_o) |-> qe_i)
        else $error("quad mode without enable");
    cover property ($rose(wip_o));
    cover property (io_oe_o == 4'hF);
    cover property ($rose(quad_mode_o));
endmodule
bind ssp_core ssp_monitor #(.ERASE_CYCLES(ERASE_CYCLES)) i_ssp_monitor (
    .clk_i(clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i), .io_oe_o(io_oe_o),
    .qe_i(qe_i), .lock_i(lock_i), .wip_o(wip_o), .wel_o(wel_o),
    .quad_mode_o(quad_mode_o), .rdpar_o(rdpar_o));

// ===== sim/ssp_host.sv
`timescale 1ns/1ps
module ssp_host (
    output logic sclk_o, // serial clock, still between frames
    output logic cs_n_o, // chip select, active low
    output logic [3:0] io_o, // host data lines
    input wire logic [3:0] line_i, // resolved wire level
    input wire logic [3:0] oe_i // device drive enables
);
    logic [63:0] rd;
    logic seen_oe;
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        io_o = 4'h0;
        rd = 64'h0;
        seen_oe = 1'b0;
    end
    // ns send clocks, nd dummy, nr read; w bits per clock
    task automatic frame(input logic [63:0] tx, input int ns, nd, nr, w);
        tx = tx << (64 - ns * w);
        rd = 64'h0;
        seen_oe = 1'b0;
        cs_n_o = 1'b0;
        for (int i = 0; i < ns + nd + nr; i++) begin
            // released lines toggle so a stale value never passes
            if (i < ns) io_o = (w == 4) ? tx[63:60] : {3'h0, tx[63]};
            else io_o = ~io_o;
            tx = tx << w;
            #80;
            if (i >= ns + nd) rd = (rd << w) | ((w == 4) ? line_i : line_i[1]);
            seen_oe = seen_oe | (|oe_i);
            sclk_o = 1'b1;
            #80 sclk_o = 1'b0;
        end
        #80 cs_n_o = 1'b1;
        #250;
    endtask
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk_i, nrst_i, qe_i, lock_i, sclk, cs_n, wip_o, wel_o, quad_mode_o;
    logic [3:0] io_i, io_o, io_oe_o, h_io;
    ssp_pkg::ssp_rdpar_t rdpar_o;
    logic [23:0] main_rd_addr_o;
    logic [7:0] main_rd_data_i;
    logic [7:0] a;
    int num_errors = 0;
    int checked = 0;
    logic [15:0] rows [10] = '{16'h9A08, 16'h9BEB, 16'h9C0C, 16'h9D20,
        16'h9E0F, 16'h9F52, 16'hA010, 16'hA1D8, 16'hA200, 16'hA300};
    assign io_i = (io_oe_o & io_o) | (~io_oe_o & h_io);
    // array answers within the cycle: the core takes the byte one edge later
    assign main_rd_data_i = main_rd_addr_o[7:0] ^ 8'h5A;
    ssp_core #(.ERASE_CYCLES(1100)) i_ssp_core (.clk_i(clk_i),
        .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io_i),
        .io_o(io_o), .io_oe_o(io_oe_o), .qe_i(qe_i), .lock_i(lock_i),
        .wip_o(wip_o), .wel_o(wel_o), .quad_mode_o(quad_mode_o),
        .rdpar_o(rdpar_o), .main_rd_addr_o(main_rd_addr_o),
        .main_rd_data_i(main_rd_data_i));
    ssp_host i_ssp_host (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(h_io),
        .line_i(io_i), .oe_i(io_oe_o));
    task automatic chk(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmd(input logic [63:0] tx, input int ns);
        i_ssp_host.frame(tx, ns, 0, 0, 1);
    endtask
    task automatic idle();
        for (int n = 0; wip_o !== 1'b0; n++) begin
            @(posedge clk_i);
            if (n > 3000) begin
                chk("busy wait", 0, 1);
                end_of_test();
            end
        end
    endtask
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        nrst_i = 1'b0;
        qe_i = 1'b0;
        lock_i = 1'b0;
        repeat (10) @(posedge clk_i);
        #2 nrst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        chk("reset", 0, {wip_o, wel_o, quad_mode_o, rdpar_o});
        for (int k = 0; k < 10; k++) begin
            i_ssp_host.frame({8'h5A, 16'h0, rows[k][15:8]}, 32, 8, 8, 1);
            chk("table", rows[k][7:0], i_ssp_host.rd[31:0]);
        end
        cmd(64'h44000000, 32);
        chk("erase no latch", 0, {wip_o, wel_o});
        cmd(64'h06, 8);
        cmd(64'h88000000, 33);
        chk("erase bad length", 1, {wip_o, wel_o});
        @(posedge clk_i) #2 lock_i = 1'b1;
        repeat (4) @(posedge clk_i);
        cmd(64'h44000000, 32);
        chk("erase locked", 1, {wip_o, wel_o});
        @(posedge clk_i) #2 lock_i = 1'b0;
        repeat (4) @(posedge clk_i);
        cmd(64'h440003FF, 32);
        chk("erase busy", 1, wip_o);
        i_ssp_host.frame(64'h48000000, 32, 8, 8, 1);
        chk("read while busy", 2, {wip_o, i_ssp_host.seen_oe});
        idle();
        chk("latch after erase", 0, wel_o);
        cmd(64'h06, 8);
        cmd(64'h420003FEA55A, 48);
        idle();
        cmd(64'h06, 8);
        cmd(64'h42000000C3, 40);
        idle();
        cmd(64'h4200000177, 40);
        i_ssp_host.frame(64'h480003FE, 32, 8, 32, 1);
        chk("sec read", 32'hA55AC3FF, i_ssp_host.rd[31:0]);
        cmd(64'hC033, 16);
        chk("serial param", 0, rdpar_o);
        cmd(64'h7700000010, 40);
        cmd(64'h38, 8);
        chk("quad refused", 1, {quad_mode_o, rdpar_o});
        @(posedge clk_i) #2 qe_i = 1'b1;
        repeat (4) @(posedge clk_i);
        cmd(64'h38, 8);
        chk("quad on", 5'h11, {quad_mode_o, rdpar_o});
        for (int k = 0; k < 4; k++) begin
            i_ssp_host.frame({8'hC0, 2'h0, 2'(k), 2'h0, 2'(k)}, 4, 0, 0, 4);
            chk("param", {2'(k), 2'(k)}, rdpar_o);
            a = 8'((8 << k) - 2);
            i_ssp_host.frame({8'h0C, 16'h0, a}, 8, 2 * k + 2, 8, 4);
            chk("wrap read", {a, a + 8'h01, 16'h0001} ^ 32'h5A5A5A5A,
                i_ssp_host.rd[31:0]);
        end
        i_ssp_host.frame(64'h06, 2, 0, 0, 4);
        i_ssp_host.frame(64'h66, 2, 0, 0, 4);
        i_ssp_host.frame(64'h99, 2, 0, 0, 4);
        chk("soft reset", 0, {wel_o, quad_mode_o, rdpar_o});
        end_of_test();
    end
endmodule
